// >>> stm_pin_model.sv
// pulse sources on the external clock and capture pins
`timescale 1ns/100ps
module stm_pin_model (
  input  wire logic CORE_CLK,
  output logic      EXT_CLOCK_PIN,
  output logic      CAPTURE_INPUT_PIN
);
  initial begin
    EXT_CLOCK_PIN = 1'b0;
    CAPTURE_INPUT_PIN = 1'b0;
  end
  // each level is held several cycles so the synchroniser cannot miss it
  task automatic ext_pulse();
    @(posedge CORE_CLK);
    EXT_CLOCK_PIN <= 1'b1;
    repeat (4) @(posedge CORE_CLK);
    EXT_CLOCK_PIN <= 1'b0;
  endtask
  task automatic cap_pulse(input int gap);
    @(posedge CORE_CLK);
    CAPTURE_INPUT_PIN <= 1'b1;
    repeat (gap) @(posedge CORE_CLK);
    CAPTURE_INPUT_PIN <= 1'b0;
    repeat (4) @(posedge CORE_CLK);
  endtask
endmodule

// >>> stm_pkg.sv
// constants, register map and carrier types of the standard timer block
package stm_pkg;

  localparam logic [7:0]  OFS_CTRL0 = 8'h00;
  localparam logic [7:0]  OFS_CTRL1 = 8'h04;
  localparam logic [7:0]  OFS_COUNT = 8'h08;
  localparam logic [7:0]  OFS_CMPA  = 8'h0c;
  localparam logic [7:0]  OFS_CMPP  = 8'h10;
  localparam logic [7:0]  OFS_FLAGS = 8'h14;

  localparam int unsigned ON_BIT       = 0;
  localparam int unsigned EXT_FALL_BIT = 1;
  localparam int unsigned FLAG_A_BIT   = 0;
  localparam int unsigned FLAG_P_BIT   = 1;

  localparam logic [7:0]  CTRL1_RST = 8'h00;
  localparam logic [15:0] COUNT_RST = 16'h0000;
  localparam logic [15:0] CMPA_RST  = 16'h0000;
  localparam logic [7:0]  CMPP_RST  = 8'h00;
  localparam logic [15:0] TICK_RST  = 16'h0000;
  localparam int unsigned TICK_DIV_DEF = 1;

  // full range of the 16-bit counter
  localparam logic [16:0] FULL_SPAN = 17'h10000;

  typedef enum logic [1:0] {
    OP_COMPARE = 2'b00,
    OP_CAPTURE = 2'b01,
    OP_PWM     = 2'b10,
    OP_TIMER   = 2'b11
  } op_t;

  localparam logic [1:0] PF_INACTIVE = 2'b00;
  localparam logic [1:0] PF_ACTIVE   = 2'b01;
  localparam logic [1:0] PF_PWM      = 2'b10;
  localparam logic [1:0] PF_PULSE    = 2'b11;
  localparam logic [1:0] CAP_RISE    = 2'b00;
  localparam logic [1:0] CAP_FALL    = 2'b01;
  localparam logic [1:0] CAP_BOTH    = 2'b10;
  localparam logic [1:0] CAP_OFF     = 2'b11;

  typedef struct packed {
    logic op_select_hi;
    logic op_select_lo;
    logic pin_function_hi;
    logic pin_function_lo;
    logic initial_level;
    logic output_invert;
    logic duty_period_swap;
    logic clear_source_select;
  } ctrl_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } apb_rsp_t;

endpackage

// >>> stm_timer.sv
// standard timer: pwm, single pulse and capture modes behind an apb slave
//
// Chosen here: the register addresses and the APB register port.
`timescale 1ns/100ps

//Contract
// - swap set: period from A, duty P*256
// - pwm clear by P or A per swap
// - pwm keeps running while pin forced
// - clear source select ignored in pwm
// - mode 10 with pin function 11: single pulse
// - pulse starts on timer_on rise, pin edge
// - pulse ends on software clear or A match
// - A match clears timer_on, sets A flag
// - pulse counter zeroed only on timer_on rise
// - mode 01 capture, edge chosen, runs on rise
// - selected edge copies counter to A, flags
// - capture counter runs until timer_on falls
// - capture: P match zeroes counter, flags
// - pin function 11 disables capture only
// - capture has no output, bits ignored
// - P compared with counter top byte
// - initial level picks active, invert flips
// - duty at least period gives full duty
// - mode 00 compare, 11 timer counter
module stm_timer
  import stm_pkg::*;
#(
  parameter int unsigned TICK_DIV = TICK_DIV_DEF
) (
  input  wire logic              CORE_CLK,
  input  wire logic              RST,
  input  wire stm_pkg::apb_req_t APB_REQ,
  output stm_pkg::apb_rsp_t      APB_RSP,
  input  wire logic              EXT_CLOCK_PIN,
  input  wire logic              CAPTURE_INPUT_PIN,
  output logic                   TIMER_OUT,
  output logic                   TIMER_OUT_EN
);
  import stm_pkg::*;

  ctrl_t       ctrl_q;
  ctrl_t       ctrl_d;
  logic        on_q;
  logic        on_d;
  logic        on_prev_q;
  logic        ext_fall_q;
  logic        ext_fall_d;
  logic [15:0] cnt_q;
  logic [15:0] cnt_d;
  logic [15:0] cmp_a_q;
  logic [15:0] cmp_a_d;
  logic [7:0]  cmp_p_q;
  logic [7:0]  cmp_p_d;
  logic        match_a_flag_q;
  logic        match_a_flag_d;
  logic        match_p_flag_q;
  logic        match_p_flag_d;
  logic [15:0] div_q;
  logic [15:0] div_d;
  logic        out_q;
  logic        out_d;
  logic        out_en_q;
  logic        out_en_d;
  logic [31:0] prdata_q;
  logic [31:0] prdata_d;
  logic        pslverr_q;
  logic        pslverr_d;
  logic [2:0]  ext_sync_q;
  logic [2:0]  cap_sync_q;

  op_t         mode;
  logic [1:0]  pin_function;
  logic        pulse_mode;
  logic        rise;
  logic        tick;
  logic [16:0] a_span;
  logic [16:0] p_span;
  logic        a_hit;
  logic        p_hit;
  logic        pwm_on;
  logic        active;
  logic        ext_edge;
  logic        cap_rise;
  logic        cap_fall;
  logic        cap_edge;
  logic        setup;
  logic        wr;

  // last counter value of a span of clocks; a span of 65536 ends at ffff
  function automatic logic [15:0] span_end(input logic [16:0] span);
    logic [16:0] last;
    last = span - 17'h00001;
    return last[15:0];
  endfunction

  function automatic logic mapped(input logic [7:0] addr);
    return (addr == OFS_CTRL0) || (addr == OFS_CTRL1) || (addr == OFS_COUNT) ||
           (addr == OFS_CMPA) || (addr == OFS_CMPP) || (addr == OFS_FLAGS);
  endfunction

  assign mode         = op_t'({ctrl_q.op_select_hi, ctrl_q.op_select_lo});
  assign pin_function = {ctrl_q.pin_function_hi, ctrl_q.pin_function_lo};
  assign pulse_mode   = (mode == OP_PWM) && (pin_function == PF_PULSE);
  assign rise         = on_q && !on_prev_q;
  assign tick         = (div_q == 16'(TICK_DIV - 1));

  // P is only matched against the top byte, so its span is P*256
  assign p_span = (cmp_p_q == 8'h00) ? FULL_SPAN : {1'b0, cmp_p_q, 8'h00};
  assign a_span = (cmp_a_q == 16'h0000) ? FULL_SPAN : {1'b0, cmp_a_q};
  assign a_hit  = (cnt_q == span_end(a_span));
  assign p_hit  = (cnt_q == span_end(p_span));

  // duty compare at 17 bits so a duty at or above the period stays on
  always_comb begin
    if (ctrl_q.duty_period_swap) begin
      pwm_on = ({1'b0, cnt_q} < p_span);
    end else begin
      pwm_on = ({1'b0, cnt_q} < a_span);
    end
  end

  // second stage feeds the third directly; the edge compare reads those two
  assign ext_edge = ext_fall_q ? (ext_sync_q[2] && !ext_sync_q[1])
                               : (!ext_sync_q[2] && ext_sync_q[1]);
  assign cap_rise = !cap_sync_q[2] && cap_sync_q[1];
  assign cap_fall = cap_sync_q[2] && !cap_sync_q[1];
  always_comb begin
    unique case (pin_function)
      CAP_RISE: cap_edge = cap_rise;
      CAP_FALL: cap_edge = cap_fall;
      CAP_BOTH: cap_edge = cap_rise || cap_fall;
      CAP_OFF:  cap_edge = 1'b0;
    endcase
  end

  assign setup = APB_REQ.psel && !APB_REQ.penable;
  assign wr    = APB_REQ.psel && APB_REQ.penable && APB_REQ.pwrite && mapped(APB_REQ.paddr);

  always_comb begin
    ctrl_d         = ctrl_q;
    on_d           = on_q;
    ext_fall_d     = ext_fall_q;
    cnt_d          = cnt_q;
    cmp_a_d        = cmp_a_q;
    cmp_p_d        = cmp_p_q;
    match_a_flag_d = match_a_flag_q;
    match_p_flag_d = match_p_flag_q;
    div_d          = tick ? TICK_RST : div_q + 16'h0001;
    active         = 1'b0;
    out_d          = ctrl_q.initial_level ^ ctrl_q.output_invert;
    out_en_d       = 1'b0;

    // software writes first, so hardware events below override them
    if (wr) begin
      unique case (APB_REQ.paddr)
        OFS_CTRL0: begin
          on_d       = APB_REQ.pwdata[ON_BIT];
          ext_fall_d = APB_REQ.pwdata[EXT_FALL_BIT];
        end
        OFS_CTRL1: ctrl_d = ctrl_t'(APB_REQ.pwdata[7:0]);
        OFS_CMPA:  cmp_a_d = APB_REQ.pwdata[15:0];
        OFS_CMPP:  cmp_p_d = APB_REQ.pwdata[7:0];
        OFS_FLAGS: begin
          if (APB_REQ.pwdata[FLAG_A_BIT]) match_a_flag_d = 1'b0;
          if (APB_REQ.pwdata[FLAG_P_BIT]) match_p_flag_d = 1'b0;
        end
        default: ;
      endcase
    end

    if (rise) begin
      cnt_d = COUNT_RST;
    end else if (on_q && tick) begin
      unique case (mode)
        OP_PWM: begin
          if (pulse_mode) begin
            cnt_d = cnt_q + 16'h0001;
            if (a_hit) begin
              on_d           = 1'b0;
              match_a_flag_d = 1'b1;
            end
          end else begin
            // period source follows the swap bit only
            if (ctrl_q.duty_period_swap ? a_hit : p_hit) begin
              cnt_d = COUNT_RST;
            end else begin
              cnt_d = cnt_q + 16'h0001;
            end
            if (a_hit) match_a_flag_d = 1'b1;
            if (p_hit) match_p_flag_d = 1'b1;
          end
        end
        OP_CAPTURE: begin
          cnt_d = p_hit ? COUNT_RST : cnt_q + 16'h0001;
          if (p_hit) match_p_flag_d = 1'b1;
        end
        default: begin
          // compare and timer modes: clear source chosen by software
          if (ctrl_q.clear_source_select ? a_hit : p_hit) begin
            cnt_d = COUNT_RST;
          end else begin
            cnt_d = cnt_q + 16'h0001;
          end
          if (a_hit) match_a_flag_d = 1'b1;
          if (p_hit && !ctrl_q.clear_source_select) match_p_flag_d = 1'b1;
        end
      endcase
    end

    if (mode == OP_CAPTURE && on_q && cap_edge) begin
      cmp_a_d        = cnt_q;
      match_a_flag_d = 1'b1;
    end

    if (pulse_mode && ext_edge) begin
      on_d = 1'b1;
    end

    // output stage; capture and timer modes leave the pin undriven
    if (mode == OP_PWM) begin
      unique case (pin_function)
        PF_INACTIVE: active = 1'b0;
        PF_ACTIVE:   active = 1'b1;
        PF_PWM:      active = pwm_on;
        PF_PULSE:    active = on_q;
      endcase
      out_d    = (active ? ctrl_q.initial_level : !ctrl_q.initial_level)
                 ^ ctrl_q.output_invert;
      out_en_d = 1'b1;
    end else if (mode == OP_CAPTURE) begin
      out_en_d = 1'b0;
    end else if (mode == OP_COMPARE) begin
      out_en_d = 1'b1;
    end
  end

  // read data captured in the setup phase, so the access phase needs no wait
  always_comb begin
    prdata_d  = prdata_q;
    pslverr_d = pslverr_q;
    if (setup) begin
      pslverr_d = !mapped(APB_REQ.paddr);
      unique case (APB_REQ.paddr)
        OFS_CTRL0: prdata_d = {30'h00000000, ext_fall_q, on_q};
        OFS_CTRL1: prdata_d = {24'h000000, ctrl_q};
        OFS_COUNT: prdata_d = {16'h0000, cnt_q};
        OFS_CMPA:  prdata_d = {16'h0000, cmp_a_q};
        OFS_CMPP:  prdata_d = {24'h000000, cmp_p_q};
        OFS_FLAGS: prdata_d = {30'h00000000, match_p_flag_q, match_a_flag_q};
        default:   prdata_d = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      ctrl_q         <= ctrl_t'(CTRL1_RST);
      on_q           <= 1'b0;
      on_prev_q      <= 1'b0;
      ext_fall_q     <= 1'b0;
      cnt_q          <= COUNT_RST;
      cmp_a_q        <= CMPA_RST;
      cmp_p_q        <= CMPP_RST;
      match_a_flag_q <= 1'b0;
      match_p_flag_q <= 1'b0;
      div_q          <= TICK_RST;
      out_q          <= 1'b0;
      out_en_q       <= 1'b0;
      prdata_q       <= 32'h00000000;
      pslverr_q      <= 1'b0;
      ext_sync_q     <= 3'h0;
      cap_sync_q     <= 3'h0;
    end else begin
      ctrl_q         <= ctrl_d;
      on_q           <= on_d;
      on_prev_q      <= on_q;
      ext_fall_q     <= ext_fall_d;
      cnt_q          <= cnt_d;
      cmp_a_q        <= cmp_a_d;
      cmp_p_q        <= cmp_p_d;
      match_a_flag_q <= match_a_flag_d;
      match_p_flag_q <= match_p_flag_d;
      div_q          <= div_d;
      out_q          <= out_d;
      out_en_q       <= out_en_d;
      prdata_q       <= prdata_d;
      pslverr_q      <= pslverr_d;
      ext_sync_q     <= {ext_sync_q[1:0], EXT_CLOCK_PIN};
      cap_sync_q     <= {cap_sync_q[1:0], CAPTURE_INPUT_PIN};
    end
  end

  assign APB_RSP.prdata  = prdata_q;
  assign APB_RSP.pready  = 1'b1;
  assign APB_RSP.pslverr = pslverr_q;
  assign TIMER_OUT       = out_q;
  assign TIMER_OUT_EN    = out_en_q;

endmodule

// >>> stm_timer_chk.sv
// port assertions for the standard timer
`timescale 1ns/100ps
module stm_timer_chk
  import stm_pkg::*;
#(
  parameter int unsigned TICK_DIV = TICK_DIV_DEF
) (
  input wire logic              CORE_CLK,
  input wire logic              RST,
  input wire stm_pkg::apb_req_t APB_REQ,
  input wire stm_pkg::apb_rsp_t APB_RSP,
  input wire logic              EXT_CLOCK_PIN,
  input wire logic              CAPTURE_INPUT_PIN,
  input wire logic              TIMER_OUT,
  input wire logic              TIMER_OUT_EN
);
  ctrl_t      ctl_q, ctl_d;
  logic       fall_q, fall_d, wr, act, ok;
  logic [1:0] op, pf;
  logic [2:0] stab_q, stab_d;
  // shadow of the control bits and how long they have been left alone
  always_comb begin
    wr     = APB_REQ.psel & APB_REQ.penable & APB_REQ.pwrite & APB_RSP.pready;
    ctl_d  = (wr && APB_REQ.paddr == OFS_CTRL1) ? ctrl_t'(APB_REQ.pwdata[7:0]) : ctl_q;
    fall_d = (wr && APB_REQ.paddr == OFS_CTRL0) ? APB_REQ.pwdata[EXT_FALL_BIT] : fall_q;
    stab_d = (ctl_d != ctl_q) ? 3'h0 : stab_q + {2'h0, stab_q != 3'h7};
    op     = {ctl_q.op_select_hi, ctl_q.op_select_lo};
    pf     = {ctl_q.pin_function_hi, ctl_q.pin_function_lo};
    act    = ctl_q.initial_level ^ ctl_q.output_invert;
    ok     = stab_q > 3'h2;
  end
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      ctl_q  <= '0;
      fall_q <= 1'b0;
      stab_q <= 3'h0;
    end else begin
      ctl_q  <= ctl_d;
      fall_q <= fall_d;
      stab_q <= stab_d;
    end
  end
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (RST);
  property p_quiet; ok && op[0] |-> !TIMER_OUT_EN; endproperty
  a_quiet: assert property (p_quiet) else $error("pin driven in mode 01 or 11");
  property p_drive; ok && !op[0] |-> TIMER_OUT_EN; endproperty
  a_drive: assert property (p_drive) else $error("pin not driven");
  property p_hold; ok && op == OP_COMPARE |-> TIMER_OUT == act; endproperty
  a_hold: assert property (p_hold) else $error("compare mode level wrong");
  property p_idle; ok && op == OP_PWM && pf == PF_INACTIVE |-> TIMER_OUT != act; endproperty
  a_idle: assert property (p_idle) else $error("forced inactive level wrong");
  property p_act; ok && op == OP_PWM && pf == PF_ACTIVE |-> TIMER_OUT == act; endproperty
  a_act: assert property (p_act) else $error("forced active level wrong");
  property p_trig;
    ok && op == OP_PWM && pf == PF_PULSE && !fall_q && TIMER_OUT != act && $rose(EXT_CLOCK_PIN)
      |-> ##[1:8] TIMER_OUT == act;
  endproperty
  a_trig: assert property (p_trig) else $error("pin edge gave no pulse");
  property p_ready; APB_REQ.psel && APB_REQ.penable |-> APB_RSP.pready; endproperty
  a_ready: assert property (p_ready) else $error("access without ready");
  property p_unmap;
    APB_REQ.psel && APB_REQ.penable && APB_REQ.paddr > OFS_FLAGS |-> APB_RSP.pslverr;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped access without error");
  c_pulse: cover property (op == OP_PWM && pf == PF_PULSE && $rose(TIMER_OUT));
  c_cap: cover property (op == OP_CAPTURE && $rose(CAPTURE_INPUT_PIN));
  c_pwm: cover property (ok && op == OP_PWM && pf == PF_PWM && $fell(TIMER_OUT));
endmodule
bind stm_timer stm_timer_chk #(.TICK_DIV(TICK_DIV)) stm_timer_chk_i (
  .CORE_CLK(CORE_CLK), .RST(RST), .APB_REQ(APB_REQ), .APB_RSP(APB_RSP),
  .EXT_CLOCK_PIN(EXT_CLOCK_PIN), .CAPTURE_INPUT_PIN(CAPTURE_INPUT_PIN),
  .TIMER_OUT(TIMER_OUT), .TIMER_OUT_EN(TIMER_OUT_EN));

// >>> stm_timer_tb_top.sv
// testbench for the standard timer: apb tasks and mode scenarios
`timescale 1ns/100ps
module stm_timer_tb_top;
  import stm_pkg::*;
  logic        clk, rst, ext_pin, cap_pin, tout, tout_en, err;
  apb_req_t    req;
  apb_rsp_t    rsp;
  logic [31:0] rd;
  logic [31:0] v [4];
  int          errors, cmp_count, hi, lo, x;
  stm_timer #(.TICK_DIV(1)) stm_timer_i (.CORE_CLK(clk), .RST(rst), .APB_REQ(req),
    .APB_RSP(rsp), .EXT_CLOCK_PIN(ext_pin), .CAPTURE_INPUT_PIN(cap_pin),
    .TIMER_OUT(tout), .TIMER_OUT_EN(tout_en));
  stm_pin_model stm_pin_model_i (.CORE_CLK(clk), .EXT_CLOCK_PIN(ext_pin),
    .CAPTURE_INPUT_PIN(cap_pin));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge clk);
    req.penable <= 1'b1;
    // only the watchdog ends a wait for ready
    do begin
      @(posedge clk);
    end while (rsp.pready !== 1'b1);
    rd = rsp.prdata;
    err = rsp.pslverr;
    req <= '0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  task automatic span(input logic lvl, output int c);
    c = 0;
    while (tout === lvl && c < 2000) begin
      @(posedge clk);
      c++;
    end
  endtask
  task automatic meas();
    span(1'b1, x);
    span(1'b0, x);
    span(1'b1, hi);
    span(1'b0, lo);
  endtask
  task automatic finish_test();
    $display("comparisons %0d errors %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    #3000000;
    errors++;
    finish_test();
  end
  initial begin
    rst = 1'b1;
    req = '0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    rdc(OFS_CTRL1, 32'h0);
    rdc(OFS_CMPA, 32'h0);
    rdc(8'h18, 32'h0);
    chk({31'h0, err}, 32'h1);
    wr(OFS_CMPP, 32'h1);
    wr(OFS_CMPA, 32'h40);
    for (int i = 0; i < 4; i++) begin
      wr(OFS_CTRL0, 32'h0);
      wr(OFS_CTRL1, {24'h0, 4'b1010, i[1], i[0], 1'b0, i[0]});
      wr(OFS_CTRL0, 32'h1);
      meas();
      chk(hi, (i[1] ^ i[0]) ? 64 : 192);
      chk(hi + lo, 256);
    end
    wr(OFS_CTRL0, 32'h0);
    wr(OFS_CMPA, 32'h258);
    wr(OFS_CMPP, 32'h2);
    wr(OFS_CTRL1, 32'haa);
    wr(OFS_CTRL0, 32'h1);
    meas();
    chk(hi, 512);
    chk(hi + lo, 600);
    wr(OFS_CTRL0, 32'h0);
    wr(OFS_CMPP, 32'h3);
    wr(OFS_CTRL0, 32'h1);
    repeat (4) @(posedge clk);
    span(1'b1, hi);
    chk(hi, 2000);
    wr(OFS_CTRL1, 32'h88);
    apb(1'b0, OFS_COUNT, 32'h0);
    x = rd;
    apb(1'b0, OFS_COUNT, 32'h0);
    chk(rd != x, 1);
    chk(tout, 0);
    wr(OFS_CTRL1, 32'h98);
    repeat (4) @(posedge clk);
    chk(tout, 1);
    wr(OFS_CTRL0, 32'h0);
    wr(OFS_FLAGS, 32'h3);
    wr(OFS_CMPA, 32'h32);
    wr(OFS_CTRL1, 32'hb8);
    wr(OFS_CTRL0, 32'h1);
    span(1'b0, x);
    span(1'b1, hi);
    chk(hi >= 50 && hi <= 51, 1);
    rdc(OFS_FLAGS, 32'h1);
    rdc(OFS_CTRL0, 32'h0);
    // pin trigger on the rising edge, then on the falling edge
    for (int e = 0; e < 2; e++) begin
      wr(OFS_CTRL0, {30'h0, e[0], 1'b0});
      fork
        stm_pin_model_i.ext_pulse();
        begin
          span(1'b0, x);
          span(1'b1, hi);
        end
      join
      chk(hi >= 50 && hi <= 51, 1);
    end
    wr(OFS_CMPA, 32'h3e8);
    wr(OFS_CTRL0, 32'h1);
    repeat (100) @(posedge clk);
    wr(OFS_CTRL0, 32'h0);
    span(1'b1, hi);
    chk(hi < 10, 1);
    wr(OFS_CMPP, 32'h1);
    for (int m = 0; m < 4; m++) begin
      wr(OFS_CTRL1, {24'h0, 2'b01, m[1:0], 4'h4});
      wr(OFS_FLAGS, 32'h3);
      wr(OFS_CMPA, 32'h0);
      wr(OFS_CTRL0, 32'h1);
      stm_pin_model_i.cap_pulse(150);
      apb(1'b0, OFS_CMPA, 32'h0);
      v[m] = rd;
      apb(1'b0, OFS_FLAGS, 32'h0);
      chk(rd[0], m != 3);
      wr(OFS_CTRL0, 32'h0);
    end
    chk(v[1] - v[0], 150);
    chk(v[2], v[1]);
    chk(v[3], 32'h0);
    wr(OFS_CTRL0, 32'h1);
    repeat (300) @(posedge clk);
    apb(1'b0, OFS_FLAGS, 32'h0);
    chk(rd[1], 1);
    apb(1'b0, OFS_COUNT, 32'h0);
    chk(rd < 256, 1);
    // compare mode clears by P, timer mode with clear select clears by A
    wr(OFS_CTRL0, 32'h0);
    wr(OFS_CMPA, 32'h64);
    for (int k = 0; k < 2; k++) begin
      wr(OFS_CTRL1, k ? 32'hc1 : 32'h00);
      wr(OFS_FLAGS, 32'h3);
      wr(OFS_CTRL0, 32'h1);
      repeat (300) @(posedge clk);
      apb(1'b0, OFS_FLAGS, 32'h0);
      chk(rd, k ? 32'h1 : 32'h3);
      apb(1'b0, OFS_COUNT, 32'h0);
      chk(rd < (k ? 100 : 256), 1);
      chk(tout_en, k == 0);
      wr(OFS_CTRL0, 32'h0);
    end
    finish_test();
  end
endmodule
